// ===== rtl/ovc_pkg.sv
// constants, register map and types of the four-port overcurrent supervisor
// assumes one 200 MHz clock and a plain one-cycle register port
package ovc_pkg;

	// ----------------------------------------------------------------
	// size and timing
	// ----------------------------------------------------------------
	localparam int NPORT = 4;
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	// recovery counts one step per four ticks
	localparam logic [1:0] SLOW_LAST = 2'h3;
	localparam logic [15:0] START_TICKS = 16'h0032;
	localparam logic [15:0] COOL_TICKS = 16'h03e8;
	localparam logic [15:0] CUT_TO_BASE = 16'h0010;
	localparam logic [15:0] LIM_TO_BASE = 16'h0008;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] A_POWER = 8'h00;
	localparam logic [7:0] A_CUT01 = 8'h01;
	localparam logic [7:0] A_CUT23 = 8'h02;
	localparam logic [7:0] A_TIMING = 8'h03;
	localparam logic [7:0] A_CFG = 8'h04;
	localparam logic [7:0] A_FAULT = 8'h05;
	localparam logic [7:0] A_SLEVT = 8'h06;
	localparam logic [7:0] A_FMASK = 8'h07;
	localparam logic [7:0] A_SLMASK = 8'h08;
	localparam int CUT_HI_LSB = 4;
	localparam int TIM_CUT_LSB = 0;
	localparam int TIM_LIM_LSB = 2;
	localparam int CFG_SELF_BIT = 4;
	localparam int CFG_RSENSE_BIT = 5;
	localparam logic [1:0] TIMING_RST = 2'h0;
	localparam logic [2:0] CUT_RST = 3'h0;
	// self-managed codes: 374 mA single curve, 645 mA doubled curve
	localparam logic [2:0] CODE_TYPE1 = 3'h0;
	localparam logic [2:0] CODE_TYPE2 = 3'h6;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF = 2'h0,
		ST_START = 2'h1,
		ST_ON = 2'h3,
		ST_COOL = 2'h2
	} port_st_e;

	function automatic logic [15:0] to_max(input logic [15:0] base, input logic [1:0] sel);
		return base << sel;
	endfunction : to_max

endpackage : ovc_pkg

// ===== rtl/port_overcurrent_supervisor.sv
// four-port overcurrent supervisor: inrush timer, timed cut tier, hard limit tier
// assumes comparator and power-good inputs are synchronous to clk_sys
//
// Summary of operation
// - inrush first, then cut and hard tiers
// - power-on starts inrush timer, inrush profile
// - still limiting at start end: off, flag
// - above cut: timer counts down, zero kills
// - below cut: slower count up, saturated
// - cut timeout field sets delay; flag, interrupt
// - three-bit code selects nominal cut threshold
// - hard limit folds back without waiting
// - high-power bit picks doubled or single curve
// - hard limit timer down; zero kills, flags
// - limit clears: slower count up, capped
// - inrush profile ignores high-power bit
// - foldback only after power good
// - short: gate to zero, foldback governs
// - host orders thresholds; self mode sets them
// - fault shutdown waits cool-down, then detect
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module port_overcurrent_supervisor (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic irq,
	input wire logic [ovc_pkg::NPORT-1:0] inrush_limiting,
	input wire logic [ovc_pkg::NPORT-1:0] above_cut,
	input wire logic [ovc_pkg::NPORT-1:0] at_hard_limit,
	input wire logic [ovc_pkg::NPORT-1:0] short_detect,
	input wire logic [ovc_pkg::NPORT-1:0] power_good,
	input wire logic [ovc_pkg::NPORT-1:0] class_type2,
	output logic [ovc_pkg::NPORT-1:0] gate_en,
	output logic [ovc_pkg::NPORT-1:0] inrush_sel,
	output logic [ovc_pkg::NPORT-1:0] fold_2x_sel,
	output logic [ovc_pkg::NPORT-1:0] gate_zero,
	output logic [ovc_pkg::NPORT-1:0] detect_restart,
	output logic [ovc_pkg::NPORT*3-1:0] cut_threshold,
	output logic reduced_sense_select
);
	import ovc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		port_st_e [NPORT-1:0] st;
		logic [NPORT-1:0][15:0] tmr;
		logic [NPORT-1:0][15:0] cut_cnt;
		logic [NPORT-1:0][15:0] lim_cnt;
		logic [NPORT-1:0][2:0] cut_code;
		logic [NPORT-1:0] hps;
		logic self_man;
		logic rsense;
		logic [1:0] cut_to;
		logic [1:0] lim_to;
		logic [NPORT-1:0] cut_flg;
		logic [NPORT-1:0] start_flg;
		logic [NPORT-1:0] lim_flg;
		logic [NPORT-1:0] fmask;
		logic [2*NPORT-1:0] slmask;
		logic [7:0] tick_cnt;
		logic [1:0] slow_cnt;
		logic [NPORT-1:0] gate_en;
		logic [NPORT-1:0] inrush;
		logic [NPORT-1:0] fold2x;
		logic [NPORT-1:0] gate_zero;
		logic [NPORT-1:0] det_restart;
		logic irq;
		logic [7:0] rd_data;
	} ovc_s;

	ovc_s s_r;
	ovc_s s_nxt;

	assign rd_data = s_r.rd_data;
	assign irq = s_r.irq;
	assign gate_en = s_r.gate_en;
	assign inrush_sel = s_r.inrush;
	assign fold_2x_sel = s_r.fold2x;
	assign gate_zero = s_r.gate_zero;
	assign detect_restart = s_r.det_restart;
	assign cut_threshold = s_r.cut_code;
	assign reduced_sense_select = s_r.rsense;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic tick;
		logic slow;
		logic lim_cond;
		logic [15:0] cmax;
		logic [15:0] lmax;
		logic [NPORT-1:0] on_cmd;
		logic [NPORT-1:0] off_cmd;
		logic [NPORT-1:0] set_cut;
		logic [NPORT-1:0] set_start;
		logic [NPORT-1:0] set_lim;
		logic [NPORT-1:0] clr_f;
		logic [2*NPORT-1:0] clr_sl;
		s_nxt = s_r;
		tick = (s_r.tick_cnt == TICK_LAST);
		slow = tick && (s_r.slow_cnt == SLOW_LAST);
		lim_cond = 1'b0;
		cmax = to_max(CUT_TO_BASE, s_r.cut_to);
		lmax = to_max(LIM_TO_BASE, s_r.lim_to);
		on_cmd = (wr_en && addr == A_POWER) ? wr_data[NPORT-1:0] : '0;
		off_cmd = (wr_en && addr == A_POWER) ? wr_data[2*NPORT-1:NPORT] : '0;
		set_cut = '0;
		set_start = '0;
		set_lim = '0;
		clr_f = '0;
		clr_sl = '0;
		s_nxt.det_restart = '0;
		s_nxt.rd_data = '0;
		s_nxt.tick_cnt = tick ? 8'h00 : s_r.tick_cnt + 8'h01;
		if (tick) begin
			s_nxt.slow_cnt = s_r.slow_cnt + 2'h1;
		end

		// configuration writes come first so a self-managed power-on wins
		if (wr_en) begin
			case (addr)
				A_CUT01: begin
					s_nxt.cut_code[0] = wr_data[2:0];
					s_nxt.cut_code[1] = wr_data[CUT_HI_LSB +: 3];
				end
				A_CUT23: begin
					s_nxt.cut_code[2] = wr_data[2:0];
					s_nxt.cut_code[3] = wr_data[CUT_HI_LSB +: 3];
				end
				A_TIMING: begin
					s_nxt.cut_to = wr_data[TIM_CUT_LSB +: 2];
					s_nxt.lim_to = wr_data[TIM_LIM_LSB +: 2];
				end
				A_CFG: begin
					s_nxt.hps = wr_data[NPORT-1:0];
					s_nxt.self_man = wr_data[CFG_SELF_BIT];
					s_nxt.rsense = wr_data[CFG_RSENSE_BIT];
				end
				A_FMASK: s_nxt.fmask = wr_data[NPORT-1:0];
				A_SLMASK: s_nxt.slmask = wr_data;
				default: ;
			endcase
		end

		// every port runs its own copy of the sequencer
		for (int i = 0; i < NPORT; i++) begin
			lim_cond = at_hard_limit[i] || short_detect[i];
			case (s_r.st[i])
				ST_OFF: begin
					if (on_cmd[i]) begin
						s_nxt.st[i] = ST_START;
						s_nxt.tmr[i] = START_TICKS;
						if (s_r.self_man) begin
							s_nxt.cut_code[i] = class_type2[i] ? CODE_TYPE2 : CODE_TYPE1;
							s_nxt.hps[i] = class_type2[i];
						end
					end
				end
				ST_START: begin
					if (off_cmd[i]) begin
						s_nxt.st[i] = ST_OFF;
						s_nxt.det_restart[i] = 1'b1;
					end else if (s_r.tmr[i] != 16'h0000) begin
						if (tick) begin
							s_nxt.tmr[i] = s_r.tmr[i] - 16'h0001;
						end
					end else if (inrush_limiting[i]) begin
						set_start[i] = 1'b1;
						s_nxt.st[i] = ST_COOL;
						s_nxt.tmr[i] = COOL_TICKS;
					end else if (power_good[i]) begin
						// inrush profile is held until power good is seen
						s_nxt.st[i] = ST_ON;
						s_nxt.cut_cnt[i] = cmax;
						s_nxt.lim_cnt[i] = lmax;
					end
				end
				ST_ON: begin
					if (off_cmd[i]) begin
						s_nxt.st[i] = ST_OFF;
						s_nxt.det_restart[i] = 1'b1;
					end else begin
						if (above_cut[i]) begin
							if (s_r.cut_cnt[i] == 16'h0000) begin
								set_cut[i] = 1'b1;
							end else if (tick) begin
								s_nxt.cut_cnt[i] = s_r.cut_cnt[i] - 16'h0001;
							end
						end else if (s_r.cut_cnt[i] > cmax) begin
							s_nxt.cut_cnt[i] = cmax;
						end else if (slow && s_r.cut_cnt[i] < cmax) begin
							s_nxt.cut_cnt[i] = s_r.cut_cnt[i] + 16'h0001;
						end
						if (lim_cond) begin
							if (s_r.lim_cnt[i] == 16'h0000) begin
								set_lim[i] = 1'b1;
							end else if (tick) begin
								s_nxt.lim_cnt[i] = s_r.lim_cnt[i] - 16'h0001;
							end
						end else if (s_r.lim_cnt[i] > lmax) begin
							s_nxt.lim_cnt[i] = lmax;
						end else if (slow && s_r.lim_cnt[i] < lmax) begin
							s_nxt.lim_cnt[i] = s_r.lim_cnt[i] + 16'h0001;
						end
						if (set_cut[i] || set_lim[i]) begin
							s_nxt.st[i] = ST_COOL;
							s_nxt.tmr[i] = COOL_TICKS;
						end
					end
				end
				ST_COOL: begin
					// power requests are ignored until the cool-down ends
					if (s_r.tmr[i] == 16'h0000) begin
						s_nxt.st[i] = ST_OFF;
						s_nxt.det_restart[i] = 1'b1;
					end else if (tick) begin
						s_nxt.tmr[i] = s_r.tmr[i] - 16'h0001;
					end
				end
				default: s_nxt.st[i] = ST_OFF;
			endcase
			s_nxt.gate_en[i] = (s_nxt.st[i] == ST_START) || (s_nxt.st[i] == ST_ON);
			s_nxt.inrush[i] = (s_nxt.st[i] == ST_START);
			s_nxt.fold2x[i] = s_nxt.hps[i] && (s_nxt.st[i] == ST_ON);
			s_nxt.gate_zero[i] = short_detect[i] && s_r.gate_en[i];
		end

		// read port; event registers clear on read, a new event wins
		if (rd_en) begin
			case (addr)
				A_POWER: s_nxt.rd_data = {s_r.inrush, s_r.gate_en};
				A_CUT01: s_nxt.rd_data = {1'b0, s_r.cut_code[1], 1'b0, s_r.cut_code[0]};
				A_CUT23: s_nxt.rd_data = {1'b0, s_r.cut_code[3], 1'b0, s_r.cut_code[2]};
				A_TIMING: s_nxt.rd_data = {4'h0, s_r.lim_to, s_r.cut_to};
				A_CFG: s_nxt.rd_data = {2'h0, s_r.rsense, s_r.self_man, s_r.hps};
				A_FAULT: begin
					s_nxt.rd_data = {4'h0, s_r.cut_flg};
					clr_f = s_r.cut_flg;
				end
				A_SLEVT: begin
					s_nxt.rd_data = {s_r.lim_flg, s_r.start_flg};
					clr_sl = {s_r.lim_flg, s_r.start_flg};
				end
				A_FMASK: s_nxt.rd_data = {4'h0, s_r.fmask};
				A_SLMASK: s_nxt.rd_data = s_r.slmask;
				default: s_nxt.rd_data = 8'h00;
			endcase
		end
		s_nxt.cut_flg = (s_r.cut_flg & ~clr_f) | set_cut;
		s_nxt.start_flg = (s_r.start_flg & ~clr_sl[NPORT-1:0]) | set_start;
		s_nxt.lim_flg = (s_r.lim_flg & ~clr_sl[2*NPORT-1:NPORT]) | set_lim;
		s_nxt.irq = |(s_nxt.cut_flg & s_nxt.fmask) || |({s_nxt.lim_flg, s_nxt.start_flg} & s_nxt.slmask);
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.cut_to <= TIMING_RST;
			s_r.lim_to <= TIMING_RST;
			s_r.cut_code <= {NPORT{CUT_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks, one assertion copy per port so every port's faults are watched; start, cut and restart covers on port 0 only
	// ----------------------------------------------------------------
	logic [15:0] cmax0;
	logic [15:0] lmax0;
	logic tick0;
	logic slow0;
	assign cmax0 = to_max(CUT_TO_BASE, s_r.cut_to);
	assign lmax0 = to_max(LIM_TO_BASE, s_r.lim_to);
	assign tick0 = (s_r.tick_cnt == TICK_LAST);
	assign slow0 = tick0 && (s_r.slow_cnt == SLOW_LAST);

	for (genvar g = 0; g < NPORT; g++) begin : g_chk
		property p_inrush_on;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_OFF && wr_en && addr == A_POWER && wr_data[g])
			|=> (gate_en[g] && inrush_sel[g] && !fold_2x_sel[g] && s_r.tmr[g] == START_TICKS);
		endproperty
		a_inrush_on: assert property (p_inrush_on) else $error("power-on did not enter inrush");

		property p_start_off;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_START && s_r.tmr[g] == 16'h0000 && inrush_limiting[g] && !(wr_en && addr == A_POWER))
			|=> (!gate_en[g] && s_r.start_flg[g] && s_r.st[g] == ST_COOL);
		endproperty
		a_start_off: assert property (p_start_off) else $error("start fault not taken");

		property p_cut_down;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON && above_cut[g] && tick0 && s_r.cut_cnt[g] != 16'h0000 && !(wr_en && addr == A_POWER))
			|=> (s_r.cut_cnt[g] == $past(s_r.cut_cnt[g]) - 16'h0001);
		endproperty
		a_cut_down: assert property (p_cut_down) else $error("cut timer did not count down");

		property p_cut_up;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON && !above_cut[g] && tick0 && !slow0 && !(wr_en && addr == A_POWER))
			|=> (s_r.cut_cnt[g] == $past(s_r.cut_cnt[g]) || $past(s_r.cut_cnt[g]) > $past(cmax0));
		endproperty
		a_cut_up: assert property (p_cut_up) else $error("cut timer recovered at full rate");

		property p_cut_fault;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON && above_cut[g] && s_r.cut_cnt[g] == 16'h0000 && !(wr_en && addr == A_POWER))
			|=> (!gate_en[g] && s_r.cut_flg[g]) ##1 irq == (s_r.fmask[g] || $past(irq));
		endproperty
		a_cut_fault: assert property (p_cut_fault) else $error("cut expiry did not power off");

		property p_fold_sel;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON && !(wr_en && addr == A_CFG) && !(wr_en && addr == A_POWER))
			|=> (fold_2x_sel[g] == (s_r.hps[g] && gate_en[g]));
		endproperty
		a_fold_sel: assert property (p_fold_sel) else $error("foldback curve not from high power bit");

		property p_lim_fault;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON && at_hard_limit[g] && s_r.lim_cnt[g] == 16'h0000 && !(wr_en && addr == A_POWER))
			|=> (!gate_en[g] && s_r.lim_flg[g] && s_r.tmr[g] == COOL_TICKS);
		endproperty
		a_lim_fault: assert property (p_lim_fault) else $error("limit expiry did not power off");

		property p_lim_cap;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON && !at_hard_limit[g] && !short_detect[g] && !wr_en)
			|=> (s_r.lim_cnt[g] <= lmax0);
		endproperty
		a_lim_cap: assert property (p_lim_cap) else $error("limit timer above its cap");

		property p_on_needs_pg;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_START ##1 s_r.st[g] == ST_ON) |-> $past(power_good[g]);
		endproperty
		a_on_needs_pg: assert property (p_on_needs_pg) else $error("foldback entered without power good");

		property p_gate_zero;
			@(posedge clk_sys) disable iff (!nrst)
			(short_detect[g] && gate_en[g]) |=> gate_zero[g];
		endproperty
		a_gate_zero: assert property (p_gate_zero) else $error("short did not zero the gate");

		property p_cool_hold;
			@(posedge clk_sys) disable iff (!nrst)
			(s_r.st[g] == ST_ON ##1 s_r.st[g] == ST_COOL) |-> !gate_en[g] [*8];
		endproperty
		a_cool_hold: assert property (p_cool_hold) else $error("port repowered during cool-down");
	end

	c_start_fault: cover property (@(posedge clk_sys) disable iff (!nrst) s_r.start_flg[0] && !$past(s_r.start_flg[0]));
	c_cut_fault: cover property (@(posedge clk_sys) disable iff (!nrst) s_r.cut_flg[0] && !$past(s_r.cut_flg[0]));
	c_lim_fault: cover property (@(posedge clk_sys) disable iff (!nrst) (|s_r.lim_flg) && irq);
	c_restart: cover property (@(posedge clk_sys) disable iff (!nrst) detect_restart[0] && $past(s_r.st[0] == ST_COOL));

endmodule : port_overcurrent_supervisor

// ===== tb/load_model.sv
// load model: pass transistor plus powered device, one per port
// assumes the bench picks each port's load behaviour with level inputs
`timescale 1ns/100ps
module load_model (
	input wire logic [3:0] gate_en,
	input wire logic [3:0] inrush_sel,
	input wire logic [3:0] stuck,
	input wire logic [3:0] ovl,
	input wire logic [3:0] hard,
	input wire logic [3:0] shrt,
	output logic [3:0] inrush_limiting,
	output logic [3:0] above_cut,
	output logic [3:0] at_hard_limit,
	output logic [3:0] short_detect,
	output logic [3:0] power_good
);
	// no current flows with the gate off, so every sense line drops
	assign inrush_limiting = gate_en & inrush_sel & stuck;
	assign power_good = gate_en & ~stuck;
	// a hard overload is above the cut level too
	assign above_cut = gate_en & ~inrush_sel & (ovl | hard | shrt);
	assign at_hard_limit = gate_en & ~inrush_sel & (hard | shrt);
	assign short_detect = gate_en & shrt;
endmodule : load_model

// ===== tb/port_overcurrent_supervisor_tb.sv
// self-checking bench of the overcurrent supervisor with a load model
// assumes 200 MHz clk_sys; package timing constants give the windows
`timescale 1ns/100ps
module port_overcurrent_supervisor_tb;
	import ovc_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [11:0] cut; logic rs;} row_s;
	logic clk_sys, nrst, wr_en, rd_en, irq, reduced_sense_select;
	logic [7:0] addr, wr_data, rd_data, q;
	logic [3:0] inr, abv, hl, sd, pg, ct2, stuck, ovl, hard, shrt;
	logic [3:0] gate_en, inrush_sel, fold_2x_sel, gate_zero, dr;
	logic [11:0] cut_threshold;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	row_s rows [7];

	port_overcurrent_supervisor i_port_overcurrent_supervisor (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
		.inrush_limiting(inr), .above_cut(abv), .at_hard_limit(hl), .short_detect(sd), .power_good(pg),
		.class_type2(ct2), .gate_en(gate_en), .inrush_sel(inrush_sel), .fold_2x_sel(fold_2x_sel),
		.gate_zero(gate_zero), .detect_restart(dr), .cut_threshold(cut_threshold),
		.reduced_sense_select(reduced_sense_select));
	load_model i_load_model (.gate_en(gate_en), .inrush_sel(inrush_sel), .stuck(stuck), .ovl(ovl),
		.hard(hard), .shrt(shrt), .inrush_limiting(inr), .above_cut(abv), .at_hard_limit(hl),
		.short_detect(sd), .power_good(pg));

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t register read %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t pins %h expected %h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic chk_win(input int k, input int lo, input int hi);
		num_checks++;
		if (k < lo || k > hi) begin
			errors++;
			$display("BAD %0t delay %0d outside %0d..%0d", $time, k, lo, hi);
		end
	endtask : chk_win

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd

	// counts cycles until the chosen flag of port p drops
	task automatic wait_low(input bit ins, input int p, input int lim, output int k);
		k = 0;
		while ((ins ? inrush_sel[p] : gate_en[p]) === 1'b1 && k < lim) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
	endtask : wait_low

	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask : step

	task automatic do_reset();
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
	endtask : do_reset

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// whole run is about 17000 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, wr_en, rd_en, addr, wr_data, stuck, ovl, hard, shrt} = '0;
		ct2 = 4'b1001;
		rows = '{'{A_CUT01, 8'h10, 8'h10, 12'h008, 1'b0}, '{A_CUT23, 8'h32, 8'h32, 12'h688, 1'b0},
			'{A_CUT01, 8'h54, 8'h54, 12'h6ac, 1'b0}, '{A_CUT23, 8'h76, 8'h76, 12'hfac, 1'b0},
			'{A_TIMING, 8'h0f, 8'h0f, 12'hfac, 1'b0}, '{A_CFG, 8'h2f, 8'h2f, 12'hfac, 1'b1},
			'{8'h09, 8'hff, 8'h00, 12'hfac, 1'b1}};
		do_reset();
		for (int i = 0; i < 7; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, q);
			chk_reg(q, rows[i].q);
			chk_pin({cut_threshold[10:0], reduced_sense_select}, {rows[i].cut[10:0], rows[i].rs});
		end
		// a power-off during inrush asks for a new detection cycle
		wr(A_POWER, 8'h02);
		#1;
		chk_pin({gate_en, inrush_sel, dr}, 12'h220);
		wr(A_POWER, 8'h20);
		#1;
		chk_pin({gate_en, inrush_sel, dr}, 12'h002);
		step();
		chk_pin({8'h00, dr}, 12'h000);
		$display("test table done");
		do_reset();
		stuck <= 4'b0100;
		#1;
		chk_pin({gate_en, inrush_sel, irq, 3'h0}, 12'h000);
		chk_pin(cut_threshold, 12'h000);
		rd(A_TIMING, q);
		chk_reg(q, 8'h00);
		$display("test reset done");
		// self mode loads codes from class; port 2 is still limiting when inrush ends
		wr(A_CFG, 8'h10);
		wr(A_POWER, 8'h0f);
		step();
		chk_pin({gate_en, inrush_sel, fold_2x_sel}, 12'hff0);
		chk_pin(cut_threshold, 12'hc06);
		wait_low(1'b1, 0, 11000, n);
		chk_win(n, 9600, 10400);
		repeat (2) step();
		chk_pin({gate_en, fold_2x_sel, irq, 3'h0}, 12'hb90);
		wr(A_SLMASK, 8'hff);
		step();
		chk_pin({11'h000, irq}, 12'h001);
		rd(A_SLEVT, q);
		chk_reg(q, 8'h04);
		step();
		chk_pin({11'h000, irq}, 12'h000);
		wr(A_POWER, 8'h04);
		repeat (2) step();
		chk_pin({8'h00, gate_en}, 12'h00b);
		$display("test start done");
		// cut tier: 8 ticks down, 8 ticks idle give two slow steps back, then 10 ticks to expiry
		wr(A_FMASK, 8'h0f);
		ovl <= 4'b0001;
		repeat (1600) @(posedge clk_sys);
		ovl <= 4'b0000;
		repeat (1600) @(posedge clk_sys);
		ovl <= 4'b0001;
		wait_low(1'b0, 0, 4000, n);
		chk_win(n, 1800, 2002);
		step();
		chk_pin({gate_en, irq, 7'h00}, 12'ha80);
		rd(A_FAULT, q);
		chk_reg(q, 8'h01);
		$display("test cut done");
		// hard limit on port 1, short on port 3
		@(posedge clk_sys);
		hard <= 4'b0010;
		shrt <= 4'b1000;
		repeat (3) step();
		chk_pin({8'h00, gate_zero}, 12'h008);
		wait_low(1'b0, 1, 2000, n);
		chk_win(n, 1300, 1800);
		repeat (3) step();
		chk_pin({8'h00, gate_en}, 12'h000);
		rd(A_SLEVT, q);
		chk_reg(q, 8'ha0);
		$display("test limit done");
		tally_and_finish();
	end
endmodule : port_overcurrent_supervisor_tb
